/* src/hst_pkg.sv */
// Shared constants and types for the display host interface pin select block.
package hst_pkg;

  // ------------------------------------------------------------------
  // Interface mode strap codes
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    HST_SPI3  = 3'h0,
    HST_SPI4  = 3'h1,
    HST_DUAL  = 3'h2,
    HST_QUAD  = 3'h3,
    HST_RGB3  = 3'h4,
    HST_RGB4  = 3'h5,
    HST_LINK  = 3'h6,
    HST_PAR8  = 3'h7
  } hst_mode_t;

  // ------------------------------------------------------------------
  // Strap capture phases
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    HST_ST_STRAP = 2'b01,
    HST_ST_RUN   = 2'b10
  } hst_phase_t;

  // ------------------------------------------------------------------
  // Serial word lengths, as the index of the last clock edge of a word
  // ------------------------------------------------------------------
  localparam logic [3:0] HST_LAST_3W   = 4'h8;
  localparam logic [3:0] HST_LAST_4W   = 4'h7;
  localparam logic [3:0] HST_LAST_DUAL = 4'h3;
  localparam logic [3:0] HST_LAST_QUAD = 4'h1;
  localparam logic [3:0] HST_CNT_RST   = 4'h0;
  localparam logic [8:0] HST_SHIFT_RST = 9'h000;

  localparam int HST_FIFO_DEPTH = 16;
  localparam int HST_WORD_W     = 12;

  // ------------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic       is_pixel;
    logic       is_cmd;
    logic       hsync_n;
    logic       vsync_n;
    logic [7:0] data;
  } hst_word_t;

  typedef struct packed {
    logic clk_p;
    logic clk_n;
    logic d0_p;
    logic d0_n;
  } hst_link_t;

  localparam hst_word_t HST_WORD_RST = 12'h000;
  localparam hst_link_t HST_LINK_RST = 4'h0;

  // ------------------------------------------------------------------
  // Mode decoding; the serial test is shared by both clock domains, the RGB test is used by the system domain only
  // ------------------------------------------------------------------
  function automatic logic hst_is_serial(input hst_mode_t m);
    hst_is_serial = (m != HST_LINK) && (m != HST_PAR8);
  endfunction : hst_is_serial

  function automatic logic hst_is_rgb(input hst_mode_t m);
    hst_is_rgb = (m == HST_RGB3) || (m == HST_RGB4);
  endfunction : hst_is_rgb

endpackage : hst_pkg

/* src/hst_pin_select.sv */
// Host interface selection, pin function multiplexing and word buffering.
`timescale 1ns/1ns
// Notes on behaviour
// - Code 000: three-wire serial, nine-bit words.
// - Code 001: four-wire serial, eight bits, select line.
// - Code 010: two lanes, lane1 on select pin.
// - Code 011: quad lanes, lanes 2-3 on data pins.
// - Codes 100/101: RGB pixels plus serial commands.
// - Code 111 parallel bus; 110 serial display link.
// - Chip select low addresses; high ignores serial and parallel activity.
// - Parallel select line: low command, high data.
// - Four-wire select line has the same meaning.
// - Write strobe: parallel write, RGB pixel clock.
// - Read strobe: parallel read, serial clock otherwise.
// - Serial data pin is line or lane 0.
// - Tearing output enabled by command, else low.
// - Swap input exchanges each link pair's roles.
// - Done flag reflects compressed processing busy state.

// ------------------------------------------------------------------
// Word FIFO with a registered head
// ------------------------------------------------------------------
module hst_fifo
  import hst_pkg::*;
#(
  parameter int WIDTH = HST_WORD_W,
  parameter int DEPTH = HST_FIFO_DEPTH
)(
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
  begin : g_bad_param
    $error("hst_fifo needs a power-of-two depth of at least 2");
  end

  typedef struct packed {
    logic [AW-1:0]  wr;
    logic [AW-1:0]  rd;
    logic [AW:0]    cnt;
    logic           ov;
    logic [WIDTH-1:0] od;
  } hst_fifo_st_t;

  hst_fifo_st_t     q;
  hst_fifo_st_t     d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  assign in_ready  = (q.cnt != (AW+1)'(DEPTH));
  assign out_valid = q.ov;
  assign out_data  = q.od;

  always_comb
  begin
    d    = q;
    push = in_valid && in_ready;
    pop  = (q.cnt != '0) && (!q.ov || out_ready);
    if (push)
    begin
      d.wr = q.wr + AW'(1);
    end
    if (pop)
    begin
      d.rd = q.rd + AW'(1);
      d.ov = 1'b1;
      d.od = mem[q.rd];
    end
    else if (out_ready)
    begin
      d.ov = 1'b0;
    end
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  // The array holds no reset; only entries counted as present are read.
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[q.wr] <= in_data;
    end
  end

endmodule : hst_fifo

// ------------------------------------------------------------------
// Top level
// ------------------------------------------------------------------
module hst_pin_select
  import hst_pkg::*;
#(
  parameter int FIFO_DEPTH = HST_FIFO_DEPTH
)(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       link_clk,
  input  wire logic [2:0] interface_mode_pins,
  input  wire logic       chip_select_n,
  input  wire logic       cmd_or_data_sel,
  input  wire logic       write_strobe_n,
  input  wire logic       read_strobe_n,
  input  wire logic       pixel_valid_in,
  input  wire logic       line_sync_n,
  input  wire logic       frame_sync_n,
  input  wire logic [7:0] rgb_pixel_bus_i,
  output logic [7:0]      rgb_pixel_bus_o,
  output logic            rgb_pixel_bus_oe,
  input  wire logic       serial_lane0_i,
  output logic            serial_lane0_o,
  output logic            serial_lane0_oe,
  input  wire logic       lane_polarity_swap,
  input  wire hst_link_t  link_pins_i,
  output hst_link_t       link_pins_o,
  input  wire logic [7:0] read_byte,
  input  wire logic       te_enable,
  input  wire logic       scan_blank,
  input  wire logic       proc_busy,
  output logic            scan_position_flag,
  output logic            proc_done,
  output logic            word_valid,
  input  wire logic       word_ready,
  output hst_word_t       word,
  output logic            overflow,
  output hst_mode_t       active_mode
);

  // ------------------------------------------------------------------
  // State carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] cnt;
    logic [8:0] shift;
    logic       first;
  } hst_frm_t;

  typedef struct packed {
    logic       tgl;
    hst_word_t  word;
  } hst_dlv_t;

  typedef struct packed {
    hst_phase_t phase;
    logic [2:0] mode_s1;
    logic [2:0] mode_s2;
    hst_mode_t  mode;
    logic       cs_s1;
    logic       cs_s2;
    logic       wr_s1;
    logic       wr_s2;
    logic       wr_prev;
    logic       rd_s1;
    logic       rd_s2;
    logic       dc_s1;
    logic       dc_s2;
    logic       de_s1;
    logic       de_s2;
    logic       hs_s1;
    logic       hs_s2;
    logic       vs_s1;
    logic       vs_s2;
    logic [7:0] db_s1;
    logic [7:0] db_s2;
    logic       swap_s1;
    logic       swap_s2;
    hst_link_t  lk_s1;
    hst_link_t  lk_s2;
    hst_link_t  lk_out;
    logic       tgl_s1;
    logic       tgl_s2;
    logic       tgl_ack;
    logic       pend;
    hst_word_t  pend_word;
    logic       overflow;
    logic       bus_oe;
    logic [7:0] bus_o;
    logic       te;
    logic       done;
  } hst_sys_t;

  localparam hst_frm_t FRM_RST = '{cnt: HST_CNT_RST, shift: HST_SHIFT_RST, first: 1'b1};
  localparam hst_dlv_t DLV_RST = '{tgl: 1'b0, word: HST_WORD_RST};

  hst_frm_t  frm_q;
  hst_frm_t  frm_d;
  hst_dlv_t  dlv_q;
  hst_dlv_t  dlv_d;
  hst_sys_t  sys_q;
  hst_sys_t  sys_d;
  logic      fifo_in_ready;

  // ------------------------------------------------------------------
  // Link domain: serial receiver clocked by the read strobe pin
  // ------------------------------------------------------------------
  // The serial pins are launched by the host against this clock, so
  // they are sampled here directly. The captured mode changes only on the
  // first system clock edge after reset, before the host may start a frame,
  // so it is read here as a static level; a synchroniser on this stopped
  // clock would still hold the old code during the first frame.
  always_comb
  begin
    logic [8:0] sh;
    logic       last;
    logic       cmd;
    sh    = frm_q.shift;
    last  = 1'b0;
    cmd   = 1'b0;
    frm_d = frm_q;
    dlv_d = dlv_q;
    case (sys_q.mode)
      HST_SPI3, HST_RGB3:
      begin
        sh   = {frm_q.shift[7:0], serial_lane0_i};
        last = (frm_q.cnt == HST_LAST_3W);
        cmd  = ~sh[8];
      end
      HST_SPI4, HST_RGB4:
      begin
        sh   = {frm_q.shift[7:0], serial_lane0_i};
        last = (frm_q.cnt == HST_LAST_4W);
        cmd  = ~cmd_or_data_sel;
      end
      HST_DUAL:
      begin
        sh   = {frm_q.shift[6:0], cmd_or_data_sel, serial_lane0_i};
        last = (frm_q.cnt == HST_LAST_DUAL);
        cmd  = frm_q.first;
      end
      HST_QUAD:
      begin
        sh   = {frm_q.shift[4:0], rgb_pixel_bus_i[1], rgb_pixel_bus_i[0],
                cmd_or_data_sel, serial_lane0_i};
        last = (frm_q.cnt == HST_LAST_QUAD);
        cmd  = frm_q.first;
      end
      default:
      begin
        sh   = frm_q.shift;
        last = 1'b0;
        cmd  = 1'b0;
      end
    endcase
    if (hst_is_serial(sys_q.mode))
    begin
      frm_d.shift = sh;
      frm_d.cnt   = last ? HST_CNT_RST : frm_q.cnt + 4'h1;
      if (last)
      begin
        frm_d.first     = 1'b0;
        dlv_d.tgl       = ~dlv_q.tgl;
        dlv_d.word      = HST_WORD_RST;
        dlv_d.word.is_cmd  = cmd;
        dlv_d.word.hsync_n = 1'b1;
        dlv_d.word.vsync_n = 1'b1;
        dlv_d.word.data    = sh[7:0];
      end
    end
  end

  // Raising chip select ends the frame and drops any partial word, even
  // when the host stops the serial clock right after the last bit.
  always_ff @(posedge link_clk or posedge chip_select_n)
  begin
    if (chip_select_n)
    begin
      frm_q <= FRM_RST;
    end
    else
    begin
      frm_q <= frm_d;
    end
  end

  always_ff @(posedge link_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dlv_q <= DLV_RST;
    end
    else
    begin
      dlv_q <= dlv_d;
    end
  end

  // ------------------------------------------------------------------
  // System domain: straps, parallel and pixel paths, word arbitration
  // ------------------------------------------------------------------
  always_comb
  begin
    hst_sys_t  smp;
    logic      ev;
    hst_word_t evw;
    logic      ser_new;
    logic      room;
    smp   = sys_q;
    ev    = 1'b0;
    evw   = HST_WORD_RST;
    sys_d = sys_q;
    sys_d.mode_s1 = interface_mode_pins;
    sys_d.mode_s2 = sys_q.mode_s1;
    sys_d.cs_s1   = chip_select_n;
    sys_d.cs_s2   = sys_q.cs_s1;
    sys_d.wr_s1   = write_strobe_n;
    sys_d.wr_s2   = sys_q.wr_s1;
    sys_d.wr_prev = sys_q.wr_s2;
    sys_d.rd_s1   = read_strobe_n;
    sys_d.rd_s2   = sys_q.rd_s1;
    sys_d.dc_s1   = cmd_or_data_sel;
    sys_d.dc_s2   = sys_q.dc_s1;
    sys_d.de_s1   = pixel_valid_in;
    sys_d.de_s2   = sys_q.de_s1;
    sys_d.hs_s1   = line_sync_n;
    sys_d.hs_s2   = sys_q.hs_s1;
    sys_d.vs_s1   = frame_sync_n;
    sys_d.vs_s2   = sys_q.vs_s1;
    sys_d.db_s1   = rgb_pixel_bus_i;
    sys_d.db_s2   = sys_q.db_s1;
    sys_d.swap_s1 = lane_polarity_swap;
    sys_d.swap_s2 = sys_q.swap_s1;
    sys_d.lk_s1   = link_pins_i;
    sys_d.lk_s2   = sys_q.lk_s1;
    sys_d.tgl_s1  = dlv_q.tgl;
    sys_d.tgl_s2  = sys_q.tgl_s1;
    ser_new = (sys_q.tgl_s2 != sys_q.tgl_ack) && hst_is_serial(sys_q.mode);
    room    = !sys_q.pend || fifo_in_ready;
    if (sys_q.pend && fifo_in_ready)
    begin
      sys_d.pend = 1'b0;
    end
    case (sys_q.phase)
      HST_ST_STRAP:
      begin
        // Straps are taken once after reset and then held.
        sys_d.mode    = hst_mode_t'(sys_q.mode_s2);
        sys_d.tgl_ack = sys_q.tgl_s2;
        sys_d.phase   = HST_ST_RUN;
      end
      HST_ST_RUN:
      begin
        if (hst_is_rgb(sys_q.mode) && sys_q.wr_s2 && !sys_q.wr_prev && sys_q.de_s2)
        begin
          ev           = 1'b1;
          evw.is_pixel = 1'b1;
          evw.hsync_n  = sys_q.hs_s2;
          evw.vsync_n  = sys_q.vs_s2;
          evw.data     = sys_q.db_s2;
        end
        else if (sys_q.mode == HST_PAR8 && !sys_q.cs_s2 && sys_q.wr_s2 && !sys_q.wr_prev)
        begin
          ev          = 1'b1;
          evw.is_cmd  = ~sys_q.dc_s2;
          evw.hsync_n = 1'b1;
          evw.vsync_n = 1'b1;
          evw.data    = sys_q.db_s2;
        end
        else if (ser_new && room)
        begin
          // A serial word waits in the link register until there is room.
          sys_d.tgl_ack = sys_q.tgl_s2;
          ev            = 1'b1;
          evw           = dlv_q.word;
        end
        if (ev)
        begin
          if (room)
          begin
            sys_d.pend      = 1'b1;
            sys_d.pend_word = evw;
          end
          else
          begin
            sys_d.overflow = 1'b1;
          end
        end
      end
      default:
      begin
        sys_d.phase = HST_ST_STRAP;
      end
    endcase
    sys_d.bus_oe = (sys_q.mode == HST_PAR8) && !sys_q.cs_s2 && !sys_q.rd_s2;
    sys_d.bus_o  = sys_d.bus_oe ? read_byte : 8'h00;
    sys_d.te     = te_enable && scan_blank;
    sys_d.done   = ~proc_busy;
    if (sys_q.mode == HST_LINK && sys_q.phase == HST_ST_RUN)
    begin
      sys_d.lk_out = sys_q.swap_s2 ?
                     '{clk_p: sys_q.lk_s2.clk_n, clk_n: sys_q.lk_s2.clk_p,
                       d0_p:  sys_q.lk_s2.d0_n,  d0_n:  sys_q.lk_s2.d0_p} :
                     sys_q.lk_s2;
    end
    else
    begin
      sys_d.lk_out = HST_LINK_RST;
    end
    if (!reset_n)
    begin
      smp           = sys_d;
      sys_d         = '0;
      sys_d.phase   = HST_ST_STRAP;
      sys_d.mode    = HST_SPI3;
      sys_d.mode_s1 = smp.mode_s1;
      sys_d.mode_s2 = smp.mode_s2;
      // Select and strobe stages start at their idle level, so that no false
      // write edge or read enable follows the release of reset.
      {sys_d.cs_s1, sys_d.cs_s2, sys_d.rd_s1, sys_d.rd_s2} = 4'hF;
      {sys_d.wr_s1, sys_d.wr_s2, sys_d.wr_prev}           = 3'h7;
      {sys_d.hs_s1, sys_d.hs_s2, sys_d.vs_s1, sys_d.vs_s2} = 4'hF;
      sys_d.done    = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    sys_q <= sys_d;
  end

  // ------------------------------------------------------------------
  // Word buffer and outputs
  // ------------------------------------------------------------------
  hst_fifo #(
    .WIDTH (HST_WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_valid  (sys_q.pend),
    .in_ready  (fifo_in_ready),
    .in_data   (sys_q.pend_word),
    .out_valid (word_valid),
    .out_ready (word_ready),
    .out_data  (word)
  );

  // Serial read-back is not carried by this block, so lane 0 stays an input.
  assign serial_lane0_o     = 1'b0;
  assign serial_lane0_oe    = 1'b0;
  assign rgb_pixel_bus_o    = sys_q.bus_o;
  assign rgb_pixel_bus_oe   = sys_q.bus_oe;
  assign link_pins_o        = sys_q.lk_out;
  assign scan_position_flag = sys_q.te;
  assign proc_done          = sys_q.done;
  assign overflow           = sys_q.overflow;
  assign active_mode        = sys_q.mode;

endmodule : hst_pin_select

/* sim/hst_pin_select_checker.sv */
// Port-level assertions for the host interface pin select block.
`timescale 1ns/1ns
module hst_pin_select_checker
  import hst_pkg::*;
#(
  parameter int FIFO_DEPTH = HST_FIFO_DEPTH
)(
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       chip_select_n,
  input wire logic       read_strobe_n,
  input wire logic       lane_polarity_swap,
  input wire hst_link_t  link_pins_i,
  input wire hst_link_t  link_pins_o,
  input wire logic [7:0] read_byte,
  input wire logic [7:0] rgb_pixel_bus_o,
  input wire logic       rgb_pixel_bus_oe,
  input wire logic       te_enable,
  input wire logic       scan_blank,
  input wire logic       scan_position_flag,
  input wire logic       proc_busy,
  input wire logic       proc_done,
  input wire hst_mode_t  active_mode
);
  hst_link_t swapped;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  assign swapped = {link_pins_i.clk_n, link_pins_i.clk_p, link_pins_i.d0_n, link_pins_i.d0_p};

  done_follow_a: assert property ($past(reset_n) |-> proc_done == !$past(proc_busy))
    else $error("done flag does not follow busy");
  tear_off_a: assert property (!te_enable |=> !scan_position_flag)
    else $error("tearing output high while disabled");
  tear_on_a: assert property (te_enable && scan_blank |=> scan_position_flag)
    else $error("tearing output missing");
  mode_hold_a: assert property ($past(reset_n) && $past(reset_n, 2) |-> $stable(active_mode))
    else $error("mode changed after capture");
  drive_mode_a: assert property (rgb_pixel_bus_oe |-> active_mode == HST_PAR8)
    else $error("data pins driven outside parallel mode");
  drive_cause_a: assert property ($rose(rgb_pixel_bus_oe) |-> $past(!chip_select_n && !read_strobe_n, 2))
    else $error("data pins driven without a selected read");
  read_value_a: assert property (rgb_pixel_bus_o == (rgb_pixel_bus_oe ? read_byte : 8'h00))
    else $error("read data wrong");
  link_idle_a: assert property (active_mode != HST_LINK |-> link_pins_o == HST_LINK_RST)
    else $error("link pins active in another mode");
  link_swap_a: assert property ((active_mode == HST_LINK && $stable(link_pins_i)
    && $stable(lane_polarity_swap))[*5] |-> link_pins_o == (lane_polarity_swap ? swapped : link_pins_i))
    else $error("link pair roles wrong");
endmodule : hst_pin_select_checker

bind hst_pin_select hst_pin_select_checker #(.FIFO_DEPTH(FIFO_DEPTH)) u_checker (
  .clk, .reset_n, .chip_select_n, .read_strobe_n, .lane_polarity_swap, .link_pins_i,
  .link_pins_o, .read_byte, .rgb_pixel_bus_o, .rgb_pixel_bus_oe, .te_enable, .scan_blank,
  .scan_position_flag, .proc_busy, .proc_done, .active_mode);

/* sim/hst_host_model.sv */
// Host processor model driving the serial and parallel host ports.
`timescale 1ns/1ns
module hst_host_model (
  output logic            link_clk,
  output logic            chip_select_n,
  output logic            cmd_or_data_sel,
  output logic            write_strobe_n,
  output logic            read_strobe_n,
  output logic            host_lane,
  output logic [7:0]      host_bus,
  input  wire logic [7:0] rgb_pixel_bus_i,
  input  wire logic       rgb_pixel_bus_oe
);
  int frames = 0;

  initial
  begin
    {link_clk, chip_select_n, cmd_or_data_sel, write_strobe_n, read_strobe_n} = 5'h0F;
    host_lane = 1'b0;
    host_bus = 8'h00;
  end

  // The serial clock stands still between frames; the start offset walks so that link
  // edges do not keep one fixed phase against the system clock.
  task automatic send_serial(input int n, input logic [8:0] bits, input logic dc,
                             input logic sel_n);
    #(frames % 3);
    frames++;
    chip_select_n = sel_n;
    cmd_or_data_sel = dc;
    for (int i = n - 1; i >= 0; i--)
    begin
      host_lane = bits[i];
      #24 link_clk = 1'b1;
      #24 link_clk = 1'b0;
    end
    #24 chip_select_n = 1'b1;
    host_lane = ~host_lane;
    #48;
  endtask : send_serial

  task automatic par_write(input logic [7:0] d, input logic dc);
    chip_select_n = 1'b0;
    cmd_or_data_sel = dc;
    host_bus = d;
    write_strobe_n = 1'b0;
    #12 write_strobe_n = 1'b1;
    #12 chip_select_n = 1'b1;
    host_bus = ~d;
    #12;
  endtask : par_write

  task automatic par_read(output logic oe, output logic [7:0] d);
    chip_select_n = 1'b0;
    read_strobe_n = 1'b0;
    #24 oe = rgb_pixel_bus_oe;
    d = rgb_pixel_bus_i;
    read_strobe_n = 1'b1;
    #24 chip_select_n = 1'b1;
    #12;
  endtask : par_read
endmodule : hst_host_model

/* sim/tb_hst_pin_select.sv */
// Self-checking testbench for the host interface pin select block.
`timescale 1ns/1ns
module tb_hst_pin_select;
  import hst_pkg::*;
  localparam int DEPTH = 4;
  logic       clk = 1'b0, reset_n = 1'b0, link_clk, chip_select_n, cmd_or_data_sel;
  logic       write_strobe_n, read_strobe_n, host_lane, serial_lane0_i, serial_lane0_o;
  logic       serial_lane0_oe, rgb_pixel_bus_oe, scan_position_flag, proc_done, word_valid;
  logic       overflow, pixel_valid_in = 1'b0, line_sync_n = 1'b1, frame_sync_n = 1'b1;
  logic       lane_polarity_swap = 1'b0, te_enable = 1'b0, scan_blank = 1'b0;
  logic       proc_busy = 1'b0, word_ready = 1'b0;
  logic [2:0] interface_mode_pins = 3'h0;
  logic [7:0] host_bus, rgb_pixel_bus_i, rgb_pixel_bus_o, read_byte = 8'hC3;
  hst_link_t  link_pins_i = HST_LINK_RST, link_pins_o;
  hst_word_t  word;
  hst_mode_t  active_mode;
  int         num_errors = 0, n_compared = 0;

  always #2 clk = ~clk;
  assign rgb_pixel_bus_i = rgb_pixel_bus_oe ? rgb_pixel_bus_o : host_bus;
  assign serial_lane0_i = serial_lane0_oe ? serial_lane0_o : host_lane;

  hst_pin_select #(.FIFO_DEPTH(DEPTH)) u_dut (
    .clk, .reset_n, .link_clk, .interface_mode_pins, .chip_select_n, .cmd_or_data_sel,
    .write_strobe_n, .read_strobe_n, .pixel_valid_in, .line_sync_n, .frame_sync_n,
    .rgb_pixel_bus_i, .rgb_pixel_bus_o, .rgb_pixel_bus_oe, .serial_lane0_i, .serial_lane0_o,
    .serial_lane0_oe, .lane_polarity_swap, .link_pins_i, .link_pins_o, .read_byte, .te_enable,
    .scan_blank, .proc_busy, .scan_position_flag, .proc_done, .word_valid, .word_ready, .word,
    .overflow, .active_mode);

  hst_host_model u_host (
    .link_clk, .chip_select_n, .cmd_or_data_sel, .write_strobe_n, .read_strobe_n, .host_lane,
    .host_bus, .rgb_pixel_bus_i, .rgb_pixel_bus_oe);

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_clk

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("FAIL %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [11:0] wd(input hst_word_t w);
    wd = {w.is_pixel, w.is_cmd, 2'b00, w.data};
  endfunction : wd

  task automatic start(input logic [2:0] m);
    reset_n = 1'b0;
    interface_mode_pins = m;
    wait_clk(3);
    reset_n = 1'b1;
    wait_clk(3);
    chk({9'h0, active_mode}, {9'h0, m});
  endtask : start

  task automatic get_word(output hst_word_t w);
    for (int n = 0; n < 200; n++)
    begin
      wait_clk(1);
      if (word_valid === 1'b1)
        break;
    end
    if (word_valid !== 1'b1)
    begin
      num_errors++;
      $display("FAIL %0t: no word delivered", $time);
    end
    w = word;
    word_ready = 1'b1;
    wait_clk(1);
    word_ready = 1'b0;
  endtask : get_word

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test

  initial
  begin
    #100000;
    num_errors++;
    $display("FAIL %0t: run timed out", $time);
    finish_test();
  end

  // ------------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------------
  initial
  begin
    hst_word_t  w;
    logic       oe;
    logic [7:0] d;
    start(3'h0);
    u_host.send_serial(9, 9'h0A5, 1'b1, 1'b0);
    get_word(w);
    chk(wd(w), 12'h4A5);
    u_host.send_serial(9, 9'h15A, 1'b1, 1'b0);
    get_word(w);
    chk(wd(w), 12'h05A);
    chk({10'h0, serial_lane0_oe, serial_lane0_o}, 12'h000);
    u_host.send_serial(9, 9'h0FF, 1'b1, 1'b1);
    wait_clk(40);
    chk({11'h0, word_valid}, 12'h000);
    start(3'h1);
    u_host.send_serial(8, 9'h03C, 1'b0, 1'b0);
    get_word(w);
    chk(wd(w), 12'h43C);
    u_host.send_serial(8, 9'h0C3, 1'b1, 1'b0);
    get_word(w);
    chk(wd(w), 12'h0C3);
    // Lane 1 is the select line, held high, so every other data bit is one.
    start(3'h2);
    u_host.send_serial(4, 9'h00A, 1'b1, 1'b0);
    get_word(w);
    chk(wd(w), 12'h4EE);
    // Lanes 3 and 2 are the two lowest data pins, idle low here.
    start(3'h3);
    u_host.send_serial(2, 9'h003, 1'b1, 1'b0);
    get_word(w);
    chk(wd(w), 12'h433);
    start(3'h7);
    {te_enable, scan_blank, proc_busy} = 3'b111;
    wait_clk(2);
    chk({10'h0, scan_position_flag, proc_done}, 12'h002);
    {te_enable, proc_busy} = 2'b00;
    wait_clk(2);
    chk({10'h0, scan_position_flag, proc_done}, 12'h001);
    u_host.par_write(8'h2C, 1'b0);
    get_word(w);
    chk(wd(w), 12'h42C);
    u_host.par_read(oe, d);
    chk({3'h0, oe, d}, 12'h1C3);
    chk({8'h0, link_pins_o}, 12'h000);
    // The far side stalls; head, buffer and pending word hold DEPTH + 2 words,
    // so the last write finds no room and is lost.
    for (int i = 0; i < DEPTH + 3; i++)
      u_host.par_write(8'(8'h10 + i), 1'b1);
    wait_clk(8);
    chk({11'h0, overflow}, 12'h001);
    for (int i = 0; i < DEPTH + 2; i++)
    begin
      get_word(w);
      chk(wd(w), {4'h0, 8'(8'h10 + i)});
    end
    wait_clk(10);
    chk({11'h0, word_valid}, 12'h000);
    start(3'h4);
    {pixel_valid_in, line_sync_n} = 2'b10;
    u_host.par_write(8'h5A, 1'b1);
    get_word(w);
    pixel_valid_in = 1'b0;
    chk({w.is_pixel, w.hsync_n, w.vsync_n, 1'b0, w.data}, 12'hA5A);
    u_host.send_serial(9, 9'h011, 1'b1, 1'b0);
    get_word(w);
    chk(wd(w), 12'h411);
    start(3'h6);
    for (int s = 0; s < 2; s++)
    begin
      lane_polarity_swap = s[0];
      link_pins_i = 4'h9;
      wait_clk(8);
      chk({8'h0, link_pins_o}, (s == 1) ? 12'h006 : 12'h009);
    end
    finish_test();
  end
endmodule : tb_hst_pin_select
